// [verilog/prc_defines.vh]
`ifndef PRC_DEFINES_VH
`define PRC_DEFINES_VH

// ****************************************************************
// Geometry
// ****************************************************************
`define PRC_NPORTS        4
`define PRC_AW            12
`define PRC_CNT_W         16

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define PRC_OFF_GLB_CTRL  12'h000
`define PRC_OFF_STATUS    12'h004
`define PRC_OFF_PORT_CTRL 12'h010
`define PRC_OFF_PORT_CNT  12'h020

// ****************************************************************
// Global control one fields
// ****************************************************************
`define PRC_G_RST_BIT     0
`define PRC_G_RSTDP_BIT   1
`define PRC_G_CRA_EN_BIT  2

// ****************************************************************
// Port control one fields
// ****************************************************************
`define PRC_P_RST_BIT     0
`define PRC_P_RSTDP_BIT   1
`define PRC_P_PD_BIT      2
`define PRC_P_TXEN_BIT    8

// ****************************************************************
// Status register fields
// ****************************************************************
`define PRC_S_GRES_BIT    0
`define PRC_S_GDP_BIT     1
`define PRC_S_PRES_LSB    4
`define PRC_S_PDP_LSB     8
`define PRC_S_PD_LSB      12

// ****************************************************************
// Reset values
// ****************************************************************
`define PRC_RST_SOFT      1'b0
`define PRC_RST_DP        1'b1
`define PRC_RST_PD        1'b1
`define PRC_RST_CRA_EN    1'b0
`define PRC_RST_TXEN      1'b0
`define PRC_RST_CNT       16'h0000

`endif

// [verilog/prc_reset_ctrl.v]
// Notes on behaviour
// - Global reset is pin low or soft bit.
// - Global reset returns all but soft bit, bus interface and test logic.
// - Processor bus outputs float while pin low.
// - Global soft bit sticks; cleared by write/pin.
// - Port reset is global reset or port bit.
// - Port reset returns port state but its bit.
// - Port soft bit sticks; cleared by write/global.
// - Data-path reset clears status, keeps control bits.
// - Clocks and rate adapter run during data-path reset.
// - Data-path reset drives both line outputs zero.
// - Pattern tester reset by dp resets or power-down.
// - Global dp bit forced one under global reset.
// - Port dp and pd bits forced under resets.
// - Clearing dp/pd bits only outside active resets.
// - Global dp signal follows global dp bit.
// - Port dp signal is global or port bit.
// - Port power-down signal follows port pd bit.
// - Test logic reset only by its own pin.
// - Resets enter asynchronously, leave on clock edge.
// - Power-down gates port clocks, never system side.
// - Line outputs low until pd and dp cleared and tx enable bit set.
`timescale 1ns/1ps
`default_nettype none
`include "prc_defines.vh"

module prc_reset_ctrl (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         proc_bus_oe,
  input  wire        test_logic_reset_pin_n,
  output wire        test_logic_reset_n,
  input  wire [3:0]  tx_line_pos_in,
  input  wire [3:0]  tx_line_neg_in,
  output wire [3:0]  tx_line_positive_out,
  output wire [3:0]  tx_line_negative_out,
  output wire        glb_reset_n,
  output reg         glb_dp_reset,
  output reg         clock_rate_adapter_en,
  output wire [3:0]  port_reset_n,
  output wire [3:0]  port_dp_reset,
  output wire [3:0]  port_powerdown,
  output wire [3:0]  port_clk_en,
  output wire [3:0]  pattern_tester_reset
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function port_hit;
    input [11:0] addr;
    input [11:0] base;
    input integer idx;
    begin
      port_hit = (addr == (base + idx[11:0] * 12'h004));
    end
  endfunction

  wire        acc_ph;
  wire        wr_en;
  wire        hit_glb;
  wire        hit_stat;
  wire [3:0]  hit_pctl;
  wire [3:0]  hit_pcnt;
  wire        hit_any;

  assign acc_ph   = psel & penable;
  // Writes land only on the edge that also sees pready high
  assign wr_en    = acc_ph & pwrite & pready;
  assign hit_glb  = (paddr == `PRC_OFF_GLB_CTRL);
  assign hit_stat = (paddr == `PRC_OFF_STATUS);
  assign hit_any  = hit_glb | hit_stat | (|hit_pctl) | (|hit_pcnt);

  // ****************************************************************
  // Pin reset release
  // ****************************************************************
  reg [1:0] pin_sync_r;
  wire      pin_n;

  // Entry stays asynchronous; release is retimed so that no flop
  // leaves reset on a pin edge that lands close to a clock edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync_r <= 2'h0;
    end else begin
      pin_sync_r <= {pin_sync_r[0], 1'b1};
    end
  end

  assign pin_n = pin_sync_r[1];

  // ****************************************************************
  // Global control one
  // ****************************************************************
  reg  glb_soft_r;
  reg  glb_dp_r;
  reg  cra_en_r;
  wire gres_n;

  // Combined reset drives async clears; the soft bit is a flop so no
  // decode glitch can reach it
  assign gres_n = pin_n & ~glb_soft_r;

  // Only the pin or a zero write clears the soft bit, so the write that set it holds
  always @(posedge pclk or negedge pin_n) begin
    if (!pin_n) begin
      glb_soft_r <= `PRC_RST_SOFT;
    end else if (wr_en && hit_glb) begin
      glb_soft_r <= pwdata[`PRC_G_RST_BIT];
    end
  end

  always @(posedge pclk or negedge gres_n) begin
    if (!gres_n) begin
      glb_dp_r <= `PRC_RST_DP;
      cra_en_r <= `PRC_RST_CRA_EN;
    end else if (wr_en && hit_glb) begin
      glb_dp_r <= pwdata[`PRC_G_RSTDP_BIT];
      cra_en_r <= pwdata[`PRC_G_CRA_EN_BIT];
    end
  end

  // Rate adapter enable is a control bit, so data-path reset leaves
  // it running and the loops keep settling
  always @(posedge pclk or negedge gres_n) begin
    if (!gres_n) begin
      clock_rate_adapter_en <= `PRC_RST_CRA_EN;
    end else begin
      clock_rate_adapter_en <= cra_en_r;
    end
  end

  always @(posedge pclk or negedge gres_n) begin
    if (!gres_n) begin
      glb_dp_reset <= 1'b1;
    end else begin
      glb_dp_reset <= glb_dp_r;
    end
  end

  // ****************************************************************
  // Global reset release
  // ****************************************************************
  reg [1:0] gsync_r;

  always @(posedge pclk or negedge gres_n) begin
    if (!gres_n) begin
      gsync_r <= 2'h0;
    end else begin
      gsync_r <= {gsync_r[0], 1'b1};
    end
  end

  assign glb_reset_n = gsync_r[1];

  // Bus outputs float only for the pin, not for the soft bit
  always @(posedge pclk or negedge pin_n) begin
    if (!pin_n) begin
      proc_bus_oe <= 1'b0;
    end else begin
      proc_bus_oe <= 1'b1;
    end
  end

  // ****************************************************************
  // Test logic reset
  // ****************************************************************
  reg [1:0] tsync_r;

  // Own pin only; chip resets never touch the scan logic
  always @(posedge pclk or negedge test_logic_reset_pin_n) begin
    if (!test_logic_reset_pin_n) begin
      tsync_r <= 2'h0;
    end else begin
      tsync_r <= {tsync_r[0], 1'b1};
    end
  end

  assign test_logic_reset_n = tsync_r[1];

  // ****************************************************************
  // Per-port control
  // ****************************************************************
  wire [127:0] pctl_rd;
  wire [127:0] pcnt_rd;

  genvar p;
  generate
    for (p = 0; p < `PRC_NPORTS; p = p + 1) begin : g_port
      reg                  psoft_r;
      reg                  pdp_r;
      reg                  ppd_r;
      reg                  ptxen_r;
      reg [15:0]           pcnt_r;
      reg [1:0]            psync_r;
      reg                  dp_o_r;
      reg                  pd_o_r;
      reg                  ce_o_r;
      reg                  pt_o_r;
      reg                  txp_r;
      reg                  txn_r;
      wire                 prst_n;
      wire                 dp_now;

      assign hit_pctl[p] = port_hit(paddr, `PRC_OFF_PORT_CTRL, p);
      assign hit_pcnt[p] = port_hit(paddr, `PRC_OFF_PORT_CNT, p);
      assign prst_n      = gres_n & ~psoft_r;
      assign dp_now      = glb_dp_r | pdp_r;

      always @(posedge pclk or negedge gres_n) begin
        if (!gres_n) begin
          psoft_r <= `PRC_RST_SOFT;
        end else if (wr_en && hit_pctl[p]) begin
          psoft_r <= pwdata[`PRC_P_RST_BIT];
        end
      end

      // A zero write cannot win while the async preset is held
      always @(posedge pclk or negedge prst_n) begin
        if (!prst_n) begin
          pdp_r   <= `PRC_RST_DP;
          ppd_r   <= `PRC_RST_PD;
          ptxen_r <= `PRC_RST_TXEN;
        end else if (wr_en && hit_pctl[p]) begin
          pdp_r   <= pwdata[`PRC_P_RSTDP_BIT];
          ppd_r   <= pwdata[`PRC_P_PD_BIT];
          ptxen_r <= pwdata[`PRC_P_TXEN_BIT];
        end
      end

      // Live-cycle counter: status, so data-path reset clears it
      always @(posedge pclk or negedge prst_n) begin
        if (!prst_n) begin
          pcnt_r <= `PRC_RST_CNT;
        end else if (dp_now) begin
          pcnt_r <= `PRC_RST_CNT;
        end else begin
          pcnt_r <= pcnt_r + 16'h0001;
        end
      end

      always @(posedge pclk or negedge prst_n) begin
        if (!prst_n) begin
          psync_r <= 2'h0;
        end else begin
          psync_r <= {psync_r[0], 1'b1};
        end
      end

      always @(posedge pclk or negedge prst_n) begin
        if (!prst_n) begin
          dp_o_r <= 1'b1;
          pd_o_r <= 1'b1;
          ce_o_r <= 1'b0;
          pt_o_r <= 1'b1;
          txp_r  <= 1'b0;
          txn_r  <= 1'b0;
        end else begin
          dp_o_r <= dp_now;
          pd_o_r <= ppd_r;
          // Clock gating follows power-down only, never data-path reset
          ce_o_r <= ~ppd_r;
          pt_o_r <= dp_now | ppd_r;
          // Line held low until both pd and dp bits are clear and the txen bit is set
          if (dp_now || ppd_r || !ptxen_r) begin
            txp_r <= 1'b0;
            txn_r <= 1'b0;
          end else begin
            txp_r <= tx_line_pos_in[p];
            txn_r <= tx_line_neg_in[p];
          end
        end
      end

      assign port_reset_n[p]         = psync_r[1];
      assign port_dp_reset[p]        = dp_o_r;
      assign port_powerdown[p]       = pd_o_r;
      assign port_clk_en[p]          = ce_o_r;
      assign pattern_tester_reset[p] = pt_o_r;
      assign tx_line_positive_out[p] = txp_r;
      assign tx_line_negative_out[p] = txn_r;
      assign pctl_rd[p*32 +: 32]     = {23'h000000, ptxen_r, 5'h00,
                                        ppd_r, pdp_r, psoft_r};
      assign pcnt_rd[p*32 +: 32]     = {16'h0000, pcnt_r};
    end
  endgenerate

  // ****************************************************************
  // Read mux and APB answer
  // ****************************************************************
  reg [31:0] rd_mux;
  integer    i;

  always @* begin
    rd_mux = 32'h00000000;
    if (hit_glb) begin
      rd_mux[`PRC_G_RST_BIT]    = glb_soft_r;
      rd_mux[`PRC_G_RSTDP_BIT]  = glb_dp_r;
      rd_mux[`PRC_G_CRA_EN_BIT] = cra_en_r;
    end
    if (hit_stat) begin
      rd_mux[`PRC_S_GRES_BIT] = ~glb_reset_n;
      rd_mux[`PRC_S_GDP_BIT]  = glb_dp_reset;
      rd_mux[`PRC_S_PRES_LSB +: 4] = ~port_reset_n;
      rd_mux[`PRC_S_PDP_LSB +: 4]  = port_dp_reset;
      rd_mux[`PRC_S_PD_LSB +: 4]   = port_powerdown;
    end
    for (i = 0; i < `PRC_NPORTS; i = i + 1) begin
      if (hit_pctl[i]) begin
        rd_mux = pctl_rd[i*32 +: 32];
      end
      if (hit_pcnt[i]) begin
        rd_mux = pcnt_rd[i*32 +: 32];
      end
    end
  end

  // One wait state: pready rises on the second access cycle; the bus
  // stays on the pin reset so a soft reset write completes cleanly
  always @(posedge pclk or negedge pin_n) begin
    if (!pin_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= acc_ph & ~pready;
      pslverr <= acc_ph & ~pready & ~hit_any;
      if (acc_ph && !pready && !pwrite) begin
        prdata <= rd_mux;
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

endmodule // prc_reset_ctrl

`default_nettype wire

// [testbench/prc_reset_ctrl_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module prc_reset_ctrl_assertions (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       proc_bus_oe,
  input wire logic       test_logic_reset_pin_n,
  input wire logic       test_logic_reset_n,
  input wire logic [3:0] tx_line_positive_out,
  input wire logic [3:0] tx_line_negative_out,
  input wire logic       glb_reset_n,
  input wire logic       glb_dp_reset,
  input wire logic [3:0] port_reset_n,
  input wire logic [3:0] port_dp_reset,
  input wire logic [3:0] port_powerdown,
  input wire logic [3:0] port_clk_en,
  input wire logic [3:0] pattern_tester_reset
);
  // ********
  // Checks
  // ********
  default clocking cb @(posedge pclk); endclocking
  // Pin reset is checked while it is held, so no disable here
  bus_float_a: assert property (!presetn |-> !proc_bus_oe && !glb_reset_n)
    else $error("bus driven or global reset idle under pin");
  gres_forces_a: assert property (!glb_reset_n [*3] |->
    glb_dp_reset && (port_dp_reset & port_powerdown) == 4'hf)
    else $error("dp or pd not forced under global reset");
  line_zero_a: assert property (disable iff (!presetn)
    ((tx_line_positive_out | tx_line_negative_out) & (port_dp_reset | port_powerdown)) == 4'h0)
    else $error("line data passes during dp reset or power-down");
  ptr_reset_a: assert property (disable iff (!presetn)
    pattern_tester_reset == (port_dp_reset | port_powerdown))
    else $error("pattern tester reset mismatch");
  clk_gate_a: assert property (disable iff (!presetn)
    port_clk_en == ~port_powerdown)
    else $error("port clock not gated by power-down");
  gdp_port_a: assert property (disable iff (!presetn)
    glb_dp_reset |-> port_dp_reset == 4'hf)
    else $error("global dp reset missing at a port");
  port_glb_a: assert property (disable iff (!presetn)
    !glb_reset_n |-> port_reset_n == 4'h0)
    else $error("port left reset under global reset");
  // Pin release is retimed twice: once at the pin, once for the global reset
  rls_sync_a: assert property (disable iff (!presetn)
    $rose(presetn) |-> !glb_reset_n ##4 glb_reset_n)
    else $error("global reset release not four edges");
  test_rst_a: assert property (!test_logic_reset_pin_n |-> !test_logic_reset_n)
    else $error("test logic not reset by its pin");
  cover property (presetn && glb_reset_n && !glb_dp_reset);
  cover property (presetn && $fell(glb_reset_n));
  cover property (presetn && !test_logic_reset_pin_n);
endmodule // prc_reset_ctrl_assertions

bind prc_reset_ctrl prc_reset_ctrl_assertions CHK (.pclk, .presetn, .proc_bus_oe,
  .test_logic_reset_pin_n, .test_logic_reset_n, .tx_line_positive_out,
  .tx_line_negative_out, .glb_reset_n, .glb_dp_reset, .port_reset_n, .port_dp_reset,
  .port_powerdown, .port_clk_en, .pattern_tester_reset);
`default_nettype wire

// [testbench/prc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module prc_host_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata,
  output var  logic [3:0]  lpos,
  output var  logic [3:0]  lneg
);
  // ********
  // Host bus and framer data
  // ********
  initial begin
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    lpos = 4'h0;
    lneg = 4'hf;
  end
  // Bit 0 toggles every cycle so a stuck output shows
  always @(posedge pclk) begin
    lpos <= lpos + 4'h5;
    lneg <= ~lpos;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // prc_host_model
`default_nettype wire

// [testbench/prc_reset_ctrl_test.sv]
`timescale 1ns/1ps
`default_nettype none
`include "prc_defines.vh"
module prc_reset_ctrl_test;
  localparam logic [11:0] GC = `PRC_OFF_GLB_CTRL;
  localparam logic [11:0] P0 = `PRC_OFF_PORT_CTRL;
  localparam logic [11:0] P1 = P0 + 12'h004;
  logic        pclk = 1'b0;
  logic        presetn = 1'b1;
  logic        trst_n = 1'b1;
  wire         psel, penable, pwrite, pready, pslverr, oe, tlr_n, g_n, gdp, cra;
  wire  [11:0] paddr;
  wire  [31:0] pwdata, prdata;
  wire  [3:0]  lp, ln, tp, tn, pr_n, pdp, ppd, pce, ptr;
  int          bad_count = 0;
  int          n_checks = 0;
  logic [31:0] rd;
  logic        er;
  always #25 pclk = ~pclk;
  prc_reset_ctrl DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .proc_bus_oe(oe), .test_logic_reset_pin_n(trst_n),
    .test_logic_reset_n(tlr_n), .tx_line_pos_in(lp), .tx_line_neg_in(ln),
    .tx_line_positive_out(tp), .tx_line_negative_out(tn), .glb_reset_n(g_n),
    .glb_dp_reset(gdp), .clock_rate_adapter_en(cra), .port_reset_n(pr_n),
    .port_dp_reset(pdp), .port_powerdown(ppd), .port_clk_en(pce),
    .pattern_tester_reset(ptr));
  prc_host_model HOST (.pclk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite,
    .paddr, .pwdata, .lpos(lp), .lneg(ln));
  // ********
  // Helpers
  // ********
  task automatic chk(input string s, input logic [31:0] v, input logic [31:0] x);
    n_checks++;
    if (v !== x) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", s, x, v);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    HOST.xfer(1'b1, a, d, rd, er);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x, input string s);
    HOST.xfer(1'b0, a, 32'h0, rd, er);
    chk(s, rd, x);
  endtask
  task automatic results;
    $display("checks %0d bad %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_defaults;
    rdc(GC, 32'h2, "glb");
    rdc(P0, 32'h6, "port0");
    rdc(`PRC_OFF_STATUS, 32'hff02, "status");
    chk("err", er, 1'b0);
    rdc(12'hffc, 32'h0, "hole");
    chk("err", er, 1'b1);
  endtask
  task automatic t_bringup;
    logic b;
    logic bn;
    wr(GC, 32'h0);
    wr(P0, 32'h100);
    idle(2);
    chk("gdp", gdp, 1'b0);
    chk("pdp", pdp, 4'he);
    chk("ppd", ppd, 4'he);
    @(posedge pclk);
    b = lp[0];
    bn = ln[0];
    #1 chk("tx", tp[0], b);
    chk("txn", tn[0], bn);
  endtask
  task automatic t_gdp;
    wr(GC, 32'h6);
    idle(2);
    chk("gdp", gdp, 1'b1);
    chk("ptr", ptr, 4'hf);
    chk("cra", cra, 1'b1);
    chk("txz", tp[0], 1'b0);
    rdc(`PRC_OFF_PORT_CNT, 32'h0, "cnt");
    rdc(P0, 32'h100, "keep");
    wr(GC, 32'h0);
    idle(2);
    chk("pdp", pdp, 4'he);
    chk("cra", cra, 1'b0);
  endtask
  task automatic t_psoft;
    wr(P1, 32'h101);
    idle(3);
    chk("prn", pr_n, 4'hd);
    rdc(P1, 32'h7, "hold");
    wr(P1, 32'h0);
    rdc(P1, 32'h6, "soft");
    wr(P1, 32'h0);
    rdc(P1, 32'h0, "clr");
    idle(3);
    chk("prn", pr_n, 4'hf);
  endtask
  task automatic t_gsoft;
    wr(GC, 32'h5);
    idle(3);
    chk("grn", g_n, 1'b0);
    chk("cra", cra, 1'b0);
    chk("oe", oe, 1'b1);
    rdc(GC, 32'h3, "gsoft");
    rdc(P0, 32'h6, "p0def");
    wr(GC, 32'h0);
    rdc(GC, 32'h2, "gclr");
  endtask
  task automatic t_pin;
    wr(GC, 32'h1);
    @(posedge pclk);
    presetn <= 1'b0;
    idle(2);
    chk("oe", oe, 1'b0);
    chk("tlr", tlr_n, 1'b1);
    @(posedge pclk);
    presetn <= 1'b1;
    idle(3);
    rdc(GC, 32'h2, "pin");
    trst_n <= 1'b0;
    idle(1);
    chk("tlr", tlr_n, 1'b0);
    chk("grn", g_n, 1'b1);
    @(posedge pclk);
    trst_n <= 1'b1;
    idle(3);
    chk("tlr", tlr_n, 1'b1);
  endtask
  initial begin
    // Falls by NBA at time zero so the async clears see a real edge
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    idle(2);
    t_defaults;
    t_bringup;
    t_gdp;
    t_psoft;
    t_gsoft;
    t_pin;
    results;
  end
  initial begin
    #200000;
    bad_count++;
    results;
  end
endmodule // prc_reset_ctrl_test
`default_nettype wire
